//--- hw/tsp_consts.svh
// timing and field constants for the timer sync/event/phase block
// assumes a 200 MHz system clock and plain port control
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH
`define TSP_CLK_PERIOD_PS 5000
`define TSP_CNT_W 16
`define TSP_CNT_MAX 16'hFFFF
`define TSP_CNT_ZERO 16'h0000
`define TSP_EDGE_RISE 2'h0
`define TSP_EDGE_FALL 2'h1
`define TSP_CLR_NONE 2'h0
`define TSP_CLR_CAPTURE 2'h1
`define TSP_CLR_DR2 2'h2
`define TSP_CLR_SYNC 2'h3
`define TSP_SRC_INTERNAL 2'h0
`define TSP_SRC_EXT1 2'h1
`define TSP_SRC_EXT2 2'h2
`define TSP_SRC_EXT3 2'h3
`define TSP_NUM_CH 7
`define TSP_MODE_SYNC_BIT 1
`define TSP_MODE_P26_BIT 4
`define TSP_MODE_P35_BIT 5
`define TSP_MODE_P47_BIT 6
`define TSP_MODE_P67_BIT 7
`endif

//--- hw/tsp_pkg.sv
// types for the timer sync/event/phase block
// imported by the single design file
package tsp_pkg;
  typedef logic [15:0] tsp_count_t;
  typedef enum logic [2:0] {
    TSP_PH_IDLE = 3'b001,
    TSP_PH_UP = 3'b010,
    TSP_PH_DOWN = 3'b100
  } tsp_phase_t;
endpackage

//--- hw/tsp_timer.sv
// seven-channel 16-bit timer: sync pair 2/3, external event counting,
// programmed periodic capture and channel 7 phase counting.
// assumes control arrives on plain ports in the ref_clk domain; ext pins async.
`timescale 1ns/1ps
`include "tsp_consts.svh"
module tsp_timer
  import tsp_pkg::*;
(
  input wire logic refClk,
  input wire logic reset,
  input wire logic [7:0] timerModeRegA,
  input wire logic phaseModeCh7,
  input wire logic [13:0] clockSrcSel,
  input wire logic [13:0] clockEdgeSel,
  input wire logic [13:0] clearSource,
  input wire logic [6:0] countEnable,
  input wire logic [6:0] captureIn,
  input wire logic [2:0] extClockIn,
  input wire logic [6:0] counterWrite,
  input wire logic [15:0] counterWriteData,
  input wire logic [6:0] generalReg1Write,
  input wire logic [6:0] generalReg2Write,
  input wire logic [6:0] dedicatedReg2Write,
  input wire logic [15:0] regWriteData,
  input wire logic [6:0] overflowClear,
  output logic [111:0] counterValue,
  output logic [111:0] generalReg1Value,
  output logic [111:0] generalReg2Value,
  output logic [6:0] overflowFlag,
  output logic [6:0] compareMatchReq,
  output logic [6:0] inputCaptureReq,
  output logic [6:0] overflowReq
);
  // pins 0 and 1 double as encoder phases a and b on channel 7
  logic [2:0] pinLevel;
  logic [2:0] pinRise;
  logic [2:0] pinFall;
  tsp_pin_filter #(
    .WIDTH(3)
  ) pinFilter (
    .refClk(refClk),
    .reset(reset),
    .pinIn(extClockIn),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );
  logic [6:0] capEvent;
  tsp_pin_filter #(
    .WIDTH(7)
  ) capFilter (
    .refClk(refClk),
    .reset(reset),
    .pinIn(captureIn),
    .level(),
    .rise(capEvent),
    .fall()
  );
  // phase decode; the other phase is read from its settled level
  wire aRise = pinRise[0];
  wire aFall = pinFall[0];
  wire bRise = pinRise[1];
  wire bFall = pinFall[1];
  wire aLvl = pinLevel[0];
  wire bLvl = pinLevel[1];
  wire phUp = (bRise & ~aLvl) | (aRise & bLvl) | (bFall & aLvl) | (aFall & ~bLvl);
  wire phDown = (bRise & aLvl) | (aRise & ~bLvl) | (bFall & ~aLvl) | (aFall & bLvl);
  tsp_phase_t phaseDir;
  always_comb begin
    case ({phUp, phDown})
      2'b10: phaseDir = TSP_PH_UP;
      2'b01: phaseDir = TSP_PH_DOWN;
      default: phaseDir = TSP_PH_IDLE;
    endcase
  end
  // per-channel registers
  tsp_count_t cnt [7];
  tsp_count_t gr1 [7];
  tsp_count_t gr2 [7];
  tsp_count_t dr2 [7];
  logic [6:0] tick;
  logic [6:0] downTick;
  logic [6:0] match1;
  logic [6:0] match2;
  logic [6:0] matchDr2;
  logic [6:0] ownClear;
  logic [6:0] doClear;
  logic [6:0] wrapEv;
  logic [6:0] capGr1;
  logic [6:0] capGr2;
  tsp_count_t gr1Src [7];
  tsp_count_t gr2Src [7];
  wire syncPair = timerModeRegA[`TSP_MODE_SYNC_BIT];
  wire p26 = timerModeRegA[`TSP_MODE_P26_BIT];
  wire p35 = timerModeRegA[`TSP_MODE_P35_BIT];
  wire p47 = timerModeRegA[`TSP_MODE_P47_BIT];
  wire p67 = timerModeRegA[`TSP_MODE_P67_BIT];
  // count-source and edge selection per channel
  always_comb begin
    logic [1:0] src;
    logic [1:0] edg;
    logic r;
    logic f;
    src = 2'h0;
    edg = 2'h0;
    r = 1'b0;
    f = 1'b0;
    for (int i = 0; i < `TSP_NUM_CH; i++) begin
      src = clockSrcSel[2*i +: 2];
      edg = clockEdgeSel[2*i +: 2];
      case (src)
        `TSP_SRC_EXT1: begin
          r = pinRise[0];
          f = pinFall[0];
        end
        `TSP_SRC_EXT2: begin
          r = pinRise[1];
          f = pinFall[1];
        end
        `TSP_SRC_EXT3: begin
          r = pinRise[2];
          f = pinFall[2];
        end
        default: begin
          r = 1'b1;
          f = 1'b0;
        end
      endcase
      if (src == `TSP_SRC_INTERNAL)
        tick[i] = countEnable[i];
      else if (edg == `TSP_EDGE_RISE)
        tick[i] = countEnable[i] & r;
      else if (edg == `TSP_EDGE_FALL)
        tick[i] = countEnable[i] & f;
      else
        tick[i] = countEnable[i] & (r | f);
      downTick[i] = 1'b0;
    end
    if (phaseModeCh7) begin
      tick[6] = countEnable[6] & (phaseDir == TSP_PH_UP);
      downTick[6] = countEnable[6] & (phaseDir == TSP_PH_DOWN);
    end
  end
  // compare and clear selection
  always_comb begin
    for (int i = 0; i < `TSP_NUM_CH; i++) begin
      match1[i] = (cnt[i] == gr1[i]);
      match2[i] = (cnt[i] == gr2[i]);
      matchDr2[i] = (cnt[i] == dr2[i]);
      case (clearSource[2*i +: 2])
        `TSP_CLR_CAPTURE: ownClear[i] = capEvent[i];
        `TSP_CLR_DR2: ownClear[i] = matchDr2[i];
        `TSP_CLR_SYNC: ownClear[i] = match1[i];
        default: ownClear[i] = 1'b0;
      endcase
    end
  end
  wire sync3Clear = syncPair & (clearSource[5:4] == `TSP_CLR_SYNC);
  always_comb begin
    doClear = ownClear;
    if (sync3Clear) begin
      doClear[2] = ownClear[1];
    end
  end
  // periodic capture routing: gr1 loads its own counter on own capture or paired match
  always_comb begin
    for (int i = 0; i < `TSP_NUM_CH; i++) begin
      capGr1[i] = capEvent[i];
      capGr2[i] = 1'b0;
      gr1Src[i] = cnt[i];
      gr2Src[i] = cnt[i];
    end
    if (p26 & matchDr2[1]) begin
      capGr1[5] = 1'b1;
    end
    if (p35 & matchDr2[2]) begin
      capGr1[4] = 1'b1;
    end
    if (p47 & matchDr2[3]) begin
      capGr1[6] = 1'b1;
    end
    if (p67 & match2[5]) begin
      capGr2[6] = 1'b1;
    end
  end
  // counter update: clear over write over count
  logic [6:0] wrEff;
  always_comb begin
    wrEff = counterWrite;
    if (syncPair & (counterWrite[1] | counterWrite[2])) begin
      wrEff[1] = 1'b1;
      wrEff[2] = 1'b1;
    end
  end
  tsp_count_t nextCnt [7];
  always_comb begin
    for (int i = 0; i < `TSP_NUM_CH; i++) begin
      wrapEv[i] = 1'b0;
      if (doClear[i])
        nextCnt[i] = `TSP_CNT_ZERO;
      else if (wrEff[i])
        nextCnt[i] = counterWriteData;
      else if (downTick[i]) begin
        nextCnt[i] = cnt[i] - 16'h0001;
        wrapEv[i] = (cnt[i] == `TSP_CNT_ZERO);
      end else if (tick[i]) begin
        nextCnt[i] = cnt[i] + 16'h0001;
        wrapEv[i] = (cnt[i] == `TSP_CNT_MAX);
      end else
        nextCnt[i] = cnt[i];
    end
  end
  // count lands one edge after the filter reports the pin edge
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        cnt[i] <= `TSP_CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        cnt[i] <= nextCnt[i];
      end
    end
  end
  // capture beats a software write in the same cycle
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        gr1[i] <= `TSP_CNT_MAX;
      end
    end else begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        if (capGr1[i])
          gr1[i] <= gr1Src[i];
        else if (generalReg1Write[i])
          gr1[i] <= regWriteData;
      end
    end
  end
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        gr2[i] <= `TSP_CNT_MAX;
      end
    end else begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        if (capGr2[i])
          gr2[i] <= gr2Src[i];
        else if (generalReg2Write[i])
          gr2[i] <= regWriteData;
      end
    end
  end
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        dr2[i] <= `TSP_CNT_MAX;
      end
    end else begin
      for (int i = 0; i < `TSP_NUM_CH; i++) begin
        if (dedicatedReg2Write[i])
          dr2[i] <= regWriteData;
      end
    end
  end
  // flag: set wins over clear, so no wrap is lost to a late clear
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      overflowFlag <= 7'h00;
    end else begin
      overflowFlag <= wrapEv | (overflowFlag & ~overflowClear);
    end
  end
  // requests are registered one cycle late; compare and capture ones stay high while their match holds
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      compareMatchReq <= 7'h00;
      inputCaptureReq <= 7'h00;
      overflowReq <= 7'h00;
    end else begin
      compareMatchReq <= match1 | matchDr2;
      inputCaptureReq <= capGr1 | capGr2;
      overflowReq <= wrapEv;
    end
  end
  always_comb begin
    for (int i = 0; i < `TSP_NUM_CH; i++) begin
      counterValue[16*i +: 16] = cnt[i];
      generalReg1Value[16*i +: 16] = gr1[i];
      generalReg2Value[16*i +: 16] = gr2[i];
    end
  end
endmodule

// three-flop sampler for asynchronous pins; a change counts only once the
// second and third flops agree, so a pin caught mid-transition cannot count twice
module tsp_pin_filter #(
  parameter int WIDTH = 3
) (
  input wire logic refClk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] settled;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] nextSettled = (agree & stage3) | (~agree & settled);
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      settled <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      settled <= nextSettled;
    end
  end
  assign level = settled;
  assign rise = agree & stage3 & ~settled;
  assign fall = agree & ~stage3 & settled;
endmodule

//--- testbench/tsp_encoder_model.sv
// two-phase encoder on pins 1 and 2, pin 3 toggles with each step
// assumes the bench spaces step requests by several clocks
`timescale 1ns/1ps
module tsp_encoder_model (
  input wire logic refClk,
  input wire logic reset,
  input wire logic stepReq,
  input wire logic stepUp,
  output logic [2:0] pins
);
  logic [1:0] pos;
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      pos <= 2'h0;
    end else if (stepReq) begin
      pos <= stepUp ? pos + 2'h1 : pos - 2'h1;
    end
  end
  // gray order: only one phase moves per step
  assign pins = {pos[0], pos[1] ^ pos[0], pos[1]};
endmodule

//--- testbench/tsp_checker.sv
// port-level timing checks for the timer block
// assumes pin histories are judged over a three-cycle window
`timescale 1ns/1ps
module tsp_checker (
  input wire logic refClk,
  input wire logic reset,
  input wire logic [7:0] timerModeRegA,
  input wire logic phaseModeCh7,
  input wire logic [13:0] clockSrcSel,
  input wire logic [13:0] clockEdgeSel,
  input wire logic [6:0] counterWrite,
  input wire logic [6:0] overflowClear,
  input wire logic [2:0] extClockIn,
  input wire logic [111:0] counterValue,
  input wire logic [6:0] overflowFlag,
  input wire logic [6:0] overflowReq
);
  default clocking @(posedge refClk); endclocking
  default disable iff (reset);
  logic [4:0] pa;
  logic [4:0] pb;
  always_ff @(posedge refClk) begin
    pa <= {pa[3:0], extClockIn[0]};
    pb <= {pb[3:0], extClockIn[1]};
  end
  // window tolerates the exact cycle placement of the count
  wire [2:0] an = pa[3:1], ao = pa[4:2], bn = pb[3:1], bo = pb[4:2];
  wire upEdge = |((bn & ~bo & ~an) | (an & ~ao & bn) | (~bn & bo & an) | (~an & ao & ~bn));
  wire [15:0] c1 = counterValue[15:0], c2 = counterValue[31:16];
  wire [15:0] c3 = counterValue[47:32], c7 = counterValue[111:96];
  property p_sync;
    timerModeRegA[1] && |counterWrite[2:1] |=> c2 == c3;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pair differs");
  property p_rise;
    {clockSrcSel[1:0], clockEdgeSel[1:0]} == 4'h4 && $changed(c1) && !$past(|counterWrite)
      |-> |(an & ~ao) && c1 == $past(c1) + 16'h0001;
  endproperty
  a_rise: assert property (p_rise) else $error("ch1 count without rising edge");
  property p_fall;
    {clockSrcSel[3:2], clockEdgeSel[3:2]} == 4'h5 && $changed(c2) && c2 != 16'h0000 && !$past(|counterWrite)
      |-> |(~an & ao);
  endproperty
  a_fall: assert property (p_fall) else $error("ch2 count without falling edge");
  property p_both;
    clockEdgeSel[5] && $changed(c3) && !$past(|counterWrite) |-> |(an ^ ao);
  endproperty
  a_both: assert property (p_both) else $error("ch3 count without edge");
  property p_dir;
    phaseModeCh7 && $changed(c7) && !$past(|counterWrite)
      |-> (c7 == $past(c7) + 16'h0001) == upEdge && (upEdge || c7 == $past(c7) - 16'h0001);
  endproperty
  a_dir: assert property (p_dir) else $error("ch7 wrong step");
  property p_wrap;
    phaseModeCh7 && !$past(|counterWrite) && (c7 == 16'h0000 && $past(c7) == 16'hFFFF
      || c7 == 16'hFFFF && $past(c7) == 16'h0000) |-> overflowFlag[6] && overflowReq[6];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without overflow");
  property p_stick;
    overflowFlag[6] && !overflowClear[6] |=> overflowFlag[6];
  endproperty
  a_stick: assert property (p_stick) else $error("overflow flag lost");
  property p_pulse;
    overflowReq[6] |=> !overflowReq[6];
  endproperty
  a_pulse: assert property (p_pulse) else $error("overflow request too long");
endmodule
bind tsp_timer tsp_checker chk (.refClk(refClk), .reset(reset), .timerModeRegA(timerModeRegA),
  .phaseModeCh7(phaseModeCh7), .clockSrcSel(clockSrcSel), .clockEdgeSel(clockEdgeSel),
  .counterWrite(counterWrite), .overflowClear(overflowClear), .extClockIn(extClockIn),
  .counterValue(counterValue), .overflowFlag(overflowFlag), .overflowReq(overflowReq));

//--- testbench/testbench.sv
// random encoder walk, event counts, periodic capture, wraps, sync write
// assumes the encoder model on the pins and the bound checker
`timescale 1ns/1ps
module testbench;
  logic refClk = 1'b0, reset = 1'b1, phaseModeCh7 = 1'b0, stepReq = 1'b0, stepUp = 1'b0, ovf;
  logic [7:0] timerModeRegA = 8'h00;
  logic [13:0] clockSrcSel = 14'h0000, clockEdgeSel = 14'h0000, clearSource = 14'h0000;
  logic [6:0] countEnable = 7'h00, counterWrite = 7'h00, dr2Write = 7'h00, overflowClear = 7'h00;
  logic [15:0] counterWriteData = 16'h0000, regWriteData = 16'h0000, e1, e2, e3, e6, e7, cap6;
  logic [2:0] extClockIn;
  logic [111:0] counterValue, generalReg1Value;
  logic [6:0] overflowFlag;
  logic [1:0] pos;
  int errTotal = 0, checkCount = 0, seed = 44931;
  always #2.5 refClk = ~refClk;
  tsp_encoder_model enc (.refClk(refClk), .reset(reset), .stepReq(stepReq), .stepUp(stepUp), .pins(extClockIn));
  tsp_timer uut (.refClk(refClk), .reset(reset), .timerModeRegA(timerModeRegA), .phaseModeCh7(phaseModeCh7),
    .clockSrcSel(clockSrcSel), .clockEdgeSel(clockEdgeSel), .clearSource(clearSource), .countEnable(countEnable),
    .captureIn(7'h00), .extClockIn(extClockIn), .counterWrite(counterWrite), .counterWriteData(counterWriteData),
    .generalReg1Write(7'h00), .generalReg2Write(7'h00), .dedicatedReg2Write(dr2Write), .regWriteData(regWriteData),
    .overflowClear(overflowClear), .counterValue(counterValue), .generalReg1Value(generalReg1Value),
    .generalReg2Value(), .overflowFlag(overflowFlag), .compareMatchReq(), .inputCaptureReq(), .overflowReq());
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmpAll;
    #1;
    chk(counterValue[15:0], e1);
    chk(counterValue[31:16], e2);
    chk(counterValue[47:32], e3);
    chk(counterValue[95:80], e6);
    chk(generalReg1Value[95:80], cap6);
    chk(counterValue[111:96], e7);
    chk({15'h0000, overflowFlag[6]}, {15'h0000, ovf});
  endtask
  task automatic step(input logic up);
    logic [1:0] np;
    np = up ? pos + 2'h1 : pos - 2'h1;
    @(posedge refClk);
    stepUp <= up;
    stepReq <= 1'b1;
    @(posedge refClk);
    stepReq <= 1'b0;
    if (np[1] & ~pos[1]) e1++;
    if (~np[1] & pos[1]) begin
      e2++;
      if (e2 == 16'h0003) begin
        e2 = 16'h0000;
        cap6 = e6;
      end
    end
    if (np[1] ^ pos[1]) e3++;
    if (np[0] ^ pos[0] ^ np[1] ^ pos[1]) e6++;
    ovf = ovf | (up ? e7 == 16'hFFFF : e7 == 16'h0000);
    e7 = up ? e7 + 16'h0001 : e7 - 16'h0001;
    pos = np;
    repeat (5) @(posedge refClk);
    cmpAll;
  endtask
  task automatic wr(input int ch, input logic [15:0] d);
    @(posedge refClk);
    counterWriteData <= d;
    counterWrite <= 7'h01 << ch;
    @(posedge refClk);
    counterWrite <= 7'h00;
    if (ch == 6) e7 = d;
    if (ch == 1 || ch == 2) begin
      e2 = d;
      e3 = d;
    end
    repeat (2) @(posedge refClk);
    cmpAll;
  endtask
  initial begin
    repeat (8) @(posedge refClk);
    reset <= 1'b0;
    {e1, e2, e3, e6, e7} = '0;
    cap6 = 16'hFFFF;
    pos = 2'h0;
    ovf = 1'b0;
    timerModeRegA <= 8'h12;
    phaseModeCh7 <= 1'b1;
    clockSrcSel <= 14'h0B15;
    clockEdgeSel <= 14'h0C24;
    clearSource <= 14'h0008;
    countEnable <= 7'h7F;
    dr2Write <= 7'h02;
    regWriteData <= 16'h0003;
    @(posedge refClk);
    dr2Write <= 7'h00;
    cmpAll;
    for (int i = 0; i < 60; i++) step(1'($random(seed)));
    $display("random walk test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge refClk);
      overflowClear <= 7'h40;
      @(posedge refClk);
      overflowClear <= 7'h00;
      ovf = 1'b0;
      wr(6, k ? 16'h0000 : 16'hFFFF);
      step(k == 0);
    end
    $display("wrap test done");
    wr(2, 16'($random(seed)));
    wr(1, 16'($random(seed)));
    $display("sync write test done");
    conclude;
  end
  initial begin
    repeat (5000) @(posedge refClk);
    errTotal++;
    conclude;
  end
endmodule
